//--- tb.sv
/*
 Self-checking bench for the trace port: random core traffic against a model
 fed with one-cycle-old inputs, two resets with both strap levels.
 Assumes top_pkg, top_trace_port and top_observer are compiled before it.
*/
`default_nettype none
`include "top_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk;
   logic srst = 1'b1;
   logic vector_base_init = 1'b1;
   logic [17:0] drv = '0;
   wire logic core_vector_write, core_vector_value, core_mem_request, core_instr_fetch;
   wire logic core_write, core_exec_valid, core_exec_flushed, core_cond_pass;
   wire logic core_copro_instr, core_access_denied, core_bus_error, core_debug_state;
   wire logic core_compressed, core_big_endian, core_wait, core_pid_write;
   wire logic copro_absent_in, copro_busy_in, trace_enable_in;
   top_pkg::top_size_t core_size = top_pkg::TOP_SIZE_BYTE;
   logic [31:0] core_address = '0, core_read_data = '0, core_write_data = '0;
   logic [31:0] core_pid_data = '0;
   logic trace_mem_request_n, trace_sequential, trace_not_executed, trace_copro_instr_n;
   logic trace_opcode_fetch_n, trace_debug_ack, trace_abort, trace_copro_absent;
   logic trace_copro_busy, trace_process_id_write, trace_compressed_state;
   logic trace_big_endian, endian_out, trace_high_vectors, trace_instr_valid;
   logic trace_write_not_read, trace_wait_indicator, copro_wait;
   logic [1:0] trace_access_size;
   logic [31:0] trace_address, trace_process_id, trace_read_data, trace_write_data;
   logic [31:0] vector_base, pa, prd, pwd, la, ep;
   logic [17:0] pb;
   logic [1:0] ps, m, cs, nx;
   logic [2:0] ha, hb;
   logic lv, es, sv, ehv, nhv;
   int errors = 0, samples_checked = 0, cyc = 0, n;
   assign {core_vector_write, core_vector_value, core_mem_request, core_instr_fetch,
      core_write, core_exec_valid, core_exec_flushed, core_cond_pass, core_copro_instr,
      core_access_denied, core_bus_error, core_debug_state, core_compressed,
      core_big_endian, core_wait, core_pid_write, copro_absent_in, copro_busy_in} = drv;
   top_trace_port top_trace_port_i (.sys_clk, .srst, .core_mem_request, .core_instr_fetch,
      .core_write, .core_size, .core_address, .core_read_data, .core_write_data,
      .core_exec_valid, .core_exec_flushed, .core_cond_pass, .core_copro_instr,
      .core_access_denied, .core_bus_error, .core_debug_state, .core_compressed,
      .core_big_endian, .core_wait, .core_pid_write, .core_pid_data, .core_vector_write,
      .core_vector_value, .copro_absent_in, .copro_busy_in, .vector_base_init,
      .trace_enable_in, .trace_mem_request_n, .trace_sequential, .trace_not_executed,
      .trace_copro_instr_n, .trace_address, .trace_opcode_fetch_n, .trace_debug_ack,
      .trace_abort, .trace_copro_absent, .trace_copro_busy, .trace_process_id,
      .trace_process_id_write, .trace_compressed_state, .trace_big_endian, .endian_out,
      .trace_high_vectors, .trace_access_size, .trace_read_data, .trace_write_data,
      .trace_instr_valid, .trace_write_not_read, .trace_wait_indicator, .copro_wait,
      .vector_base);
   top_observer top_observer_i (.sys_clk, .srst, .trace_wait_indicator,
      .trace_instr_valid, .trace_enable_in, .instr_count());
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   function automatic logic seq_exp(logic req, logic comp, logic [31:0] a, logic [31:0] l);
      return req && (a == l || a == l + (comp ? `TOP_STEP_NARROW : `TOP_STEP_WIDE));
   endfunction
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Model sees what the port sampled one edge earlier
   task automatic step();
      @(posedge sys_clk);
      pb = drv;
      pa = core_address;
      prd = core_read_data;
      pwd = core_write_data;
      ps = core_size;
      sv = lv && pb[15];
      es = seq_exp(pb[15], pb[5], pa, la);
      if (pb[15]) begin
         la = pa;
         lv = 1'b1;
      end
      if (pb[2])
         ep = core_pid_data;
      ha = {ha[1:0], pb[1]};
      hb = {hb[1:0], pb[0]};
      // Handshake wait: answer is absent high or busy low, seen after the synchroniser
      case (cs)
         2'h0: nx = pb[9] ? 2'h1 : 2'h0;
         2'h1: nx = (ha[2] || !hb[2]) ? 2'h2 : 2'h1;
         default: nx = 2'h0;
      endcase
      cs = nx;
      ehv = nhv;
      if (pb[17])
         nhv = pb[16];
      m = 2'($urandom_range(3));
      drv <= 18'($urandom);
      core_address <= (m == 2'h3) ? $urandom : core_address + {29'h0, m, 1'b0};
      core_read_data <= $urandom;
      core_write_data <= $urandom;
      core_pid_data <= $urandom;
      core_size <= top_pkg::top_size_t'(2'($urandom_range(2)));
      @(negedge sys_clk);
      chk("mem_request_n", trace_mem_request_n, !pb[15]);
      chk("sequential", trace_sequential, sv && es);
      chk("not_executed", trace_not_executed, pb[12] && !pb[10]);
      chk("copro_instr_n", trace_copro_instr_n, !(pb[9] || nx == 2'h1));
      chk("copro_wait", copro_wait, nx == 2'h1);
      chk("address", trace_address, pa);
      chk("opcode_fetch_n", trace_opcode_fetch_n, !pb[14]);
      chk("debug_ack", trace_debug_ack, pb[6]);
      chk("abort", trace_abort, pb[8] || pb[7]);
      chk("copro_copies", {trace_copro_absent, trace_copro_busy}, {ha[2], hb[2]});
      chk("process_id", {trace_process_id_write, trace_process_id}, {pb[2], ep});
      chk("compressed", trace_compressed_state, pb[5]);
      chk("endian", {trace_big_endian, endian_out}, {2{pb[4]}});
      if (n > 0) chk("vectors", {trace_high_vectors, vector_base},
         {ehv, ehv ? `TOP_VEC_HIGH : `TOP_VEC_LOW});
      chk("size_rdata", {trace_access_size, trace_read_data}, {ps, prd});
      chk("wdata", trace_write_data, pwd);
      chk("instr_valid", trace_instr_valid, pb[12] && !pb[11]);
      chk("write_not_read", trace_write_not_read, pb[13]);
      chk("wait", trace_wait_indicator, pb[3]);
      n++;
   endtask
   task automatic run(input int len);
      lv = 1'b0;
      la = `TOP_ADDR_RESET;
      ep = `TOP_PID_RESET;
      ha = 3'h0;
      hb = 3'h0;
      cs = 2'h0;
      ehv = vector_base_init;
      nhv = vector_base_init;
      n = 0;
      repeat (len) step();
   endtask
   // Strap moves only under reset; four cycles let its synchroniser settle
   task automatic do_reset(input logic strap);
      @(posedge sys_clk);
      srst <= 1'b1;
      drv <= '0;
      vector_base_init <= strap;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("reset_n", {trace_mem_request_n, trace_copro_instr_n, trace_opcode_fetch_n},
         3'h7);
      chk("reset_pid", trace_process_id, `TOP_PID_RESET);
      @(posedge sys_clk);
      srst <= 1'b0;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      void'($urandom(73130));
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      run(300);
      $display("test random_strap_high done");
      do_reset(1'b0);
      run(200);
      $display("test random_strap_low done");
      final_report();
   end
endmodule // tb
`default_nettype wire

//--- top_map.svh
/*
 Constants for the trace observation port: widths, address steps, vector bases, reset values.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef TOP_MAP_SVH
`define TOP_MAP_SVH
`define TOP_ADDR_W 32
`define TOP_DATA_W 32
`define TOP_PID_W 32
`define TOP_SIZE_W 2
`define TOP_STEP_WIDE 32'h0000_0004
`define TOP_STEP_NARROW 32'h0000_0002
`define TOP_VEC_LOW 32'h0000_0000
`define TOP_VEC_HIGH 32'hffff_0000
`define TOP_PID_RESET 32'h0000_0000
`define TOP_ADDR_RESET 32'h0000_0000
`endif

//--- top_observer.sv
/*
 Behavioural trace observer standing at the far side of the trace port.
 Assumes the port's outputs change on sys_clk and srst is synchronous, active high.
*/
`default_nettype none
module top_observer (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic trace_wait_indicator,
   input wire logic trace_instr_valid,
   output logic trace_enable_in,
   output logic [15:0] instr_count
);
   timeunit 1ns;
   timeprecision 1ns;
   // Wait only qualifies a sample, it never gates our clock
   wire logic take = trace_instr_valid && !trace_wait_indicator;
   always @(posedge sys_clk) begin
      if (srst) begin
         trace_enable_in <= 1'b0;
         instr_count <= 16'h0000;
      end else begin
         trace_enable_in <= 1'b1;
         if (take)
            instr_count <= instr_count + 16'h0001;
      end
   end
endmodule // top_observer
`default_nettype wire

//--- top_pkg.sv
/*
 Types shared by the trace observation port.
 Assumes top_map.svh is available on the include path.
*/
`default_nettype none
`include "top_map.svh"
package top_pkg;
   typedef enum logic [1:0] {
      TOP_SIZE_BYTE = 2'h0,
      TOP_SIZE_HALF = 2'h1,
      TOP_SIZE_WORD = 2'h2
   } top_size_t;
   typedef enum logic [1:0] {
      TOP_CP_IDLE = 2'h0,
      TOP_CP_WAIT = 2'h1,
      TOP_CP_DONE = 2'h2
   } top_cp_state_t;
endpackage
`default_nettype wire

//--- top_trace_port.sv
/*
 Trace observation port: registers the core's bus and pipeline status each cycle
 and presents it to an attached trace observer. Also holds the vector-base bit.
 Assumes core-side inputs come from logic on sys_clk; coprocessor handshake
 inputs and the vector-select strap come from pins and are synchronised here.
*/
// Notes on behaviour
// - Memory request output low in the cycle before a needed memory access.
// - Sequential high only for same address, plus four wide, plus two compressed.
// - Not-executed output high whenever the execute-stage instruction is skipped.
// - Coprocessor instruction output low, waiting for absent/busy response.
// - Trace address is a retimed copy of the internal address bus.
// - Opcode-fetch output low on instruction fetch, high on data transfer.
// - Debug acknowledge high in debug state, low in normal state.
// - Abort output set when an access is disallowed or bus-errors.
// - Buffered copies of coprocessor absent and busy inputs.
// - Process identifier on bus, write pulse when that register is written.
// - Compressed-state output high in 16-bit set, low in 32-bit set.
// - Both endianness outputs high for big-endian, low for little-endian.
// - High-vectors output low for base zero, high for top base.
// - Access size, read data and write data buses presented.
// - Instruction-valid high only for valid unflushed execute-stage instruction.
// - Direction output high on writes, low on reads.
// - Wait indicator flags core stalls; observer treats it as a qualifier.
// - Vector-base bit loaded from the synchronised vector-select input in the first cycle after reset.
`default_nettype none
`include "top_map.svh"
module top_trace_port #(
   parameter int ADDR_W = `TOP_ADDR_W,
   parameter int DATA_W = `TOP_DATA_W,
   parameter int PID_W = `TOP_PID_W
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic core_mem_request,
   input wire logic core_instr_fetch,
   input wire logic core_write,
   input wire top_pkg::top_size_t core_size,
   input wire logic [ADDR_W-1:0] core_address,
   input wire logic [DATA_W-1:0] core_read_data,
   input wire logic [DATA_W-1:0] core_write_data,
   input wire logic core_exec_valid,
   input wire logic core_exec_flushed,
   input wire logic core_cond_pass,
   input wire logic core_copro_instr,
   input wire logic core_access_denied,
   input wire logic core_bus_error,
   input wire logic core_debug_state,
   input wire logic core_compressed,
   input wire logic core_big_endian,
   input wire logic core_wait,
   input wire logic core_pid_write,
   input wire logic [PID_W-1:0] core_pid_data,
   input wire logic core_vector_write,
   input wire logic core_vector_value,
   input wire logic copro_absent_in,
   input wire logic copro_busy_in,
   input wire logic vector_base_init,
   input wire logic trace_enable_in,
   output logic trace_mem_request_n,
   output logic trace_sequential,
   output logic trace_not_executed,
   output logic trace_copro_instr_n,
   output logic [ADDR_W-1:0] trace_address,
   output logic trace_opcode_fetch_n,
   output logic trace_debug_ack,
   output logic trace_abort,
   output logic trace_copro_absent,
   output logic trace_copro_busy,
   output logic [PID_W-1:0] trace_process_id,
   output logic trace_process_id_write,
   output logic trace_compressed_state,
   output logic trace_big_endian,
   output logic endian_out,
   output logic trace_high_vectors,
   output logic [1:0] trace_access_size,
   output logic [DATA_W-1:0] trace_read_data,
   output logic [DATA_W-1:0] trace_write_data,
   output logic trace_instr_valid,
   output logic trace_write_not_read,
   output logic trace_wait_indicator,
   output logic copro_wait,
   output logic [ADDR_W-1:0] vector_base
);
   localparam logic [ADDR_W-1:0] STEP_WIDE = ADDR_W'(`TOP_STEP_WIDE);
   localparam logic [ADDR_W-1:0] STEP_NARROW = ADDR_W'(`TOP_STEP_NARROW);

   // Two-flop synchronisers for pin inputs; first stage read by second only
   localparam int SYNC_N = 3;
   logic [SYNC_N-1:0] pin_raw;
   logic [SYNC_N-1:0] sync_a;
   logic [SYNC_N-1:0] sync_b;
   logic absent_s;
   logic busy_s;
   logic vinit_s;
   assign pin_raw = {vector_base_init, copro_busy_in, copro_absent_in};
   assign absent_s = sync_b[0];
   assign busy_s = sync_b[1];
   assign vinit_s = sync_b[2];
   // No reset here: the strap must pass through while reset is held
   for (genvar gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
         sync_a[gi] <= pin_raw[gi];
         sync_b[gi] <= sync_a[gi];
      end
   end

   // Previous access address, tracked only for real memory cycles
   logic [ADDR_W-1:0] last_addr;
   logic have_last;
   logic [ADDR_W-1:0] step;
   logic [ADDR_W-1:0] next_step_addr;
   logic next_sequential;
   assign step = core_compressed ? STEP_NARROW : STEP_WIDE;
   assign next_step_addr = last_addr + step;
   assign next_sequential = core_mem_request && have_last &&
      (core_address == last_addr || core_address == next_step_addr);

   // Strap caught by a clocked process, held until released
   logic vec_bit;
   logic strap_pending;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         strap_pending <= 1'b1;
         vec_bit <= 1'b0;
      end else if (strap_pending) begin
         strap_pending <= 1'b0;
         vec_bit <= vinit_s;
      end else if (core_vector_write) begin
         vec_bit <= core_vector_value;
      end
   end

   // Coprocessor handshake wait
   top_pkg::top_cp_state_t cp_state;
   top_pkg::top_cp_state_t next_cp_state;
   logic cp_answer;
   assign cp_answer = absent_s || !busy_s;
   always_comb begin
      next_cp_state = cp_state;
      case (cp_state)
         top_pkg::TOP_CP_IDLE: begin
            if (core_copro_instr) next_cp_state = top_pkg::TOP_CP_WAIT;
         end
         top_pkg::TOP_CP_WAIT: begin
            if (cp_answer) next_cp_state = top_pkg::TOP_CP_DONE;
         end
         top_pkg::TOP_CP_DONE: begin
            next_cp_state = top_pkg::TOP_CP_IDLE;
         end
         default: next_cp_state = top_pkg::TOP_CP_IDLE;
      endcase
   end

   logic next_copro_wait;
   assign next_copro_wait = (next_cp_state == top_pkg::TOP_CP_WAIT);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cp_state <= top_pkg::TOP_CP_IDLE;
         copro_wait <= 1'b0;
         trace_copro_instr_n <= 1'b1;
      end else begin
         cp_state <= next_cp_state;
         copro_wait <= next_copro_wait;
         trace_copro_instr_n <= !(core_copro_instr || next_copro_wait);
      end
   end

   // Bus qualifiers, all retimed on sys_clk
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         last_addr <= ADDR_W'(`TOP_ADDR_RESET);
         have_last <= 1'b0;
         trace_mem_request_n <= 1'b1;
         trace_sequential <= 1'b0;
         trace_address <= ADDR_W'(`TOP_ADDR_RESET);
         trace_opcode_fetch_n <= 1'b1;
         trace_write_not_read <= 1'b0;
         trace_access_size <= 2'h0;
         trace_read_data <= '0;
         trace_write_data <= '0;
         trace_abort <= 1'b0;
      end else begin
         if (core_mem_request) begin
            last_addr <= core_address;
            have_last <= 1'b1;
         end
         trace_mem_request_n <= !core_mem_request;
         trace_sequential <= next_sequential;
         trace_address <= core_address;
         trace_opcode_fetch_n <= !core_instr_fetch;
         trace_write_not_read <= core_write;
         trace_access_size <= core_size;
         trace_read_data <= core_read_data;
         trace_write_data <= core_write_data;
         trace_abort <= core_access_denied || core_bus_error;
      end
   end

   // Pipeline and state outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         trace_instr_valid <= 1'b0;
         trace_not_executed <= 1'b0;
         trace_debug_ack <= 1'b0;
         trace_copro_absent <= 1'b0;
         trace_copro_busy <= 1'b0;
         trace_process_id <= PID_W'(`TOP_PID_RESET);
         trace_process_id_write <= 1'b0;
         trace_compressed_state <= 1'b0;
         trace_big_endian <= 1'b0;
         endian_out <= 1'b0;
         trace_high_vectors <= 1'b0;
         vector_base <= ADDR_W'(`TOP_VEC_LOW);
         trace_wait_indicator <= 1'b0;
      end else begin
         trace_instr_valid <= core_exec_valid && !core_exec_flushed;
         trace_not_executed <= core_exec_valid && !core_cond_pass;
         trace_debug_ack <= core_debug_state;
         trace_copro_absent <= absent_s;
         trace_copro_busy <= busy_s;
         if (core_pid_write) trace_process_id <= core_pid_data;
         trace_process_id_write <= core_pid_write;
         trace_compressed_state <= core_compressed;
         trace_big_endian <= core_big_endian;
         endian_out <= core_big_endian;
         trace_high_vectors <= vec_bit;
         vector_base <= vec_bit ? ADDR_W'(`TOP_VEC_HIGH) : ADDR_W'(`TOP_VEC_LOW);
         // Qualifier only; the observer keeps its own clock running
         trace_wait_indicator <= core_wait;
      end
   end

   // Trace enable is observed only; tracing itself lives in the observer
   logic trace_enabled_seen;
   always_ff @(posedge sys_clk) begin
      if (srst) trace_enabled_seen <= 1'b0;
      else trace_enabled_seen <= trace_enable_in;
   end

   property p_mreq;
      @(posedge sys_clk) disable iff (srst)
      core_mem_request |=> !trace_mem_request_n;
   endproperty
   a_mreq: assert property (p_mreq) else $error("mem request not low");

   property p_seq;
      @(posedge sys_clk) disable iff (srst)
      trace_sequential |-> !trace_mem_request_n;
   endproperty
   a_seq: assert property (p_seq) else $error("sequential without request");

   property p_nexec;
      @(posedge sys_clk) disable iff (srst)
      (core_exec_valid && !core_cond_pass) |=> trace_not_executed;
   endproperty
   a_nexec: assert property (p_nexec) else $error("not executed missing");

   property p_cpi;
      @(posedge sys_clk) disable iff (srst)
      copro_wait |-> !trace_copro_instr_n;
   endproperty
   a_cpi: assert property (p_cpi) else $error("copro instr high while waiting");

   property p_addr;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_address == $past(core_address);
   endproperty
   a_addr: assert property (p_addr) else $error("address not retimed");

   property p_abort;
      @(posedge sys_clk) disable iff (srst)
      (core_access_denied || core_bus_error) |=> trace_abort;
   endproperty
   a_abort: assert property (p_abort) else $error("abort missed");

   property p_pid;
      @(posedge sys_clk) disable iff (srst)
      core_pid_write |=> trace_process_id_write && trace_process_id == $past(core_pid_data);
   endproperty
   a_pid: assert property (p_pid) else $error("process id write wrong");

   property p_endian;
      @(posedge sys_clk) disable iff (srst)
      trace_big_endian == endian_out;
   endproperty
   a_endian: assert property (p_endian) else $error("endian outputs differ");

   property p_valid;
      @(posedge sys_clk) disable iff (srst)
      core_exec_flushed |=> !trace_instr_valid;
   endproperty
   a_valid: assert property (p_valid) else $error("flushed shown valid");

   property p_hivec;
      @(posedge sys_clk) disable iff (srst)
      trace_high_vectors |-> vector_base == ADDR_W'(`TOP_VEC_HIGH);
   endproperty
   a_hivec: assert property (p_hivec) else $error("vector base mismatch");

   // Sampled reset in the antecedent keeps the release cycle from being judged
   property p_rst;
      @(posedge sys_clk)
      srst |=> trace_mem_request_n && trace_copro_instr_n && !trace_sequential && !copro_wait;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at reset level");

   property p_opc;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_opcode_fetch_n == !$past(core_instr_fetch);
   endproperty
   a_opc: assert property (p_opc) else $error("opcode fetch not retimed");

   property p_dbg;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_debug_ack == $past(core_debug_state);
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug ack not retimed");

   property p_cpcopy;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_copro_absent == $past(copro_absent_in, 3) &&
         trace_copro_busy == $past(copro_busy_in, 3);
   endproperty
   a_cpcopy: assert property (p_cpcopy) else $error("handshake copies wrong");

   property p_cmp;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_compressed_state == $past(core_compressed);
   endproperty
   a_cmp: assert property (p_cmp) else $error("instruction set state wrong");

   property p_data;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_read_data == $past(core_read_data) &&
         trace_write_data == $past(core_write_data) &&
         trace_access_size == $past(core_size);
   endproperty
   a_data: assert property (p_data) else $error("size or data buses wrong");

   property p_rw;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_write_not_read == $past(core_write);
   endproperty
   a_rw: assert property (p_rw) else $error("direction wrong");

   property p_wait;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_wait_indicator == $past(core_wait);
   endproperty
   a_wait: assert property (p_wait) else $error("wait indicator wrong");

   property p_ivalid;
      @(posedge sys_clk) disable iff (srst)
      !srst |=> trace_instr_valid == ($past(core_exec_valid) && !$past(core_exec_flushed));
   endproperty
   a_ivalid: assert property (p_ivalid) else $error("instruction valid wrong");

   property p_strap;
      @(posedge sys_clk) disable iff (srst)
      (strap_pending && !srst) |-> ##2 trace_high_vectors == $past(vector_base_init, 4);
   endproperty
   a_strap: assert property (p_strap) else $error("vector bit not loaded from strap");

   property p_cpdone;
      @(posedge sys_clk) disable iff (srst)
      (copro_wait && cp_answer) |=> !copro_wait;
   endproperty
   a_cpdone: assert property (p_cpdone) else $error("wait held after answer");

   property p_cpstart;
      @(posedge sys_clk) disable iff (srst)
      core_copro_instr |=> !trace_copro_instr_n;
   endproperty
   a_cpstart: assert property (p_cpstart) else $error("copro instr not shown");

   property p_pidhold;
      @(posedge sys_clk) disable iff (srst)
      (!srst && !core_pid_write) |=> $stable(trace_process_id);
   endproperty
   a_pidhold: assert property (p_pidhold) else $error("process id changed unwritten");
endmodule // top_trace_port
`default_nettype wire
